// *** design/ipc_pkg.sv ***
// Summary of operation
// - Accepted password keeps locked sectors writable until power loss or next presentation.
// - Present command: four bytes MSB first, code 09h, same four bytes; all acknowledged.
// - Differing password copies skip comparison and leave access rights unchanged.
// - Stop in tenth-bit slot after last acknowledge starts delay; other stops nothing.
// - Delay compares received password with stored; full match grants access at end.
// - During the delay the data line stays released and all bus activity ignored.
// - Write-password updates only the bus password and needs a prior accepted presentation.
// - Newly written password becomes active for comparisons immediately after the cycle.
// - Delivered stored password is zero and already active.
// - Write command: same header, four new bytes MSB first, code 07h, bytes again.
// - Differing new-password copies leave the stored password untouched.
// - Stop in tenth-bit slot after write command starts write cycle; bus ignored meanwhile.
// - Select code matched as 1010, system bit one, two chip-select bits; ack ninth slot.
// - Device is slave only; master starts transfers and supplies the clock.
// - Start is data falling while clock high, watched except during internal cycles and from a byte's eighth rising edge until its acknowledge ends.
// - Stop is data rising while clock high; ends communication or starts cycle.
// - After eight bits the receiver pulls data low in the ninth pulse.
// - Data sampled on rising clock edges; master changes data only while clock low.
// - Respond only when chip-select bits match pins; otherwise stand by.
// - Each of 64 lock bits protects its sector; granted password overrides protection.
package ipc_pkg;
	localparam logic [3:0]  TYPE_NIBBLE    = 4'hA;
	localparam logic [7:0]  ADDR_HIGH      = 8'h09;
	localparam logic [7:0]  ADDR_LOW       = 8'h00;
	localparam logic [7:0]  CODE_PRESENT   = 8'h09;
	localparam logic [7:0]  CODE_WRITE     = 8'h07;
	localparam logic [31:0] PASSWORD_RESET = 32'h0000_0000;
	localparam int          CLK_PERIOD_NS  = 8;
	localparam int          WRITE_TIME_NS  = 5000000;
	localparam int          WRITE_CYCLES   = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int          SECTORS        = 64;
	localparam logic [3:0]  BYTE_SELECT    = 4'h0;
	localparam logic [3:0]  BYTE_ADDR_HIGH = 4'h1;
	localparam logic [3:0]  BYTE_ADDR_LOW  = 4'h2;
	localparam logic [3:0]  BYTE_CODE      = 4'h7;
	localparam logic [3:0]  BYTE_LAST      = 4'hB;
	localparam logic [3:0]  BITS_DATA      = 4'h8;

	typedef enum logic [5:0] {
		IPC_IDLE  = 6'b000001,
		IPC_RECV  = 6'b000010,
		IPC_ACK   = 6'b000100,
		IPC_TENTH = 6'b001000,
		IPC_WAIT  = 6'b010000,
		IPC_BUSY  = 6'b100000
	} ipc_state_t;
endpackage : ipc_pkg

// *** design/ipc_i2c_password_slave.sv ***
module ipc_i2c_password_slave #(
	parameter int WRITE_CYCLES = ipc_pkg::WRITE_CYCLES
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        reset,
	// Bus pins.
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Chip-select straps and sector locks.
	input  wire logic        chip_select_high_pin,
	input  wire logic        chip_select_low_pin,
	input  wire logic [63:0] sector_lock,
	// Status.
	output logic             password_granted,
	output logic [63:0]      sector_writable,
	output logic             busy,
	output logic [31:0]      active_password
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_d;
	logic       sda_d;
	logic [1:0] cs_sync_h;
	logic [1:0] cs_sync_l;

	// Pins are sampled twice before use; the first stage feeds nothing else.
	always_ff @(posedge clk) begin
		scl_sync  <= {scl_sync[0], scl};
		sda_sync  <= {sda_sync[0], sda_in};
		cs_sync_h <= {cs_sync_h[0], chip_select_high_pin};
		cs_sync_l <= {cs_sync_l[0], chip_select_low_pin};
		scl_d     <= scl_sync[1];
		sda_d     <= sda_sync[1];
	end

	wire scl_rise = scl_sync[1] & ~scl_d;
	wire scl_fall = ~scl_sync[1] & scl_d;
	wire start_ev = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	wire stop_ev  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	function automatic logic select_ok(input logic [7:0] b, input logic h, input logic l);
		select_ok = (b[7:4] == ipc_pkg::TYPE_NIBBLE) && b[3] && (b[2] == h)
			&& (b[1] == l) && !b[0];
	endfunction : select_ok

	ipc_pkg::ipc_state_t state;
	ipc_pkg::ipc_state_t next_state;
	logic [3:0]          bit_cnt;
	logic [3:0]          next_bit_cnt;
	logic [3:0]          byte_cnt;
	logic [3:0]          next_byte_cnt;
	logic [7:0]          shift;
	logic [7:0]          next_shift;
	logic [31:0]         first_copy;
	logic [31:0]         next_first_copy;
	logic [31:0]         second_copy;
	logic [31:0]         next_second_copy;
	logic                is_write;
	logic                next_is_write;
	logic                frame_ok;
	logic                next_frame_ok;
	logic                cycle_write;
	logic                next_cycle_write;
	logic [31:0]         timer;
	logic [31:0]         next_timer;
	logic                granted;
	logic                next_granted;
	logic [31:0]         stored;
	logic [31:0]         next_stored;
	logic                ack_drive;
	logic                next_ack_drive;

	always_comb begin
		logic [7:0] b;
		b                = {shift[6:0], sda_sync[1]};
		next_state       = state;
		next_bit_cnt     = bit_cnt;
		next_byte_cnt    = byte_cnt;
		next_shift       = shift;
		next_first_copy  = first_copy;
		next_second_copy = second_copy;
		next_is_write    = is_write;
		next_frame_ok    = frame_ok;
		next_cycle_write = cycle_write;
		next_timer       = timer;
		next_granted     = granted;
		next_stored      = stored;
		next_ack_drive   = ack_drive;
		case (state)
			ipc_pkg::IPC_BUSY: begin
				// Bus ignored, start included, until the self-timed cycle ends.
				next_ack_drive = 1'b0;
				if (timer == 32'(WRITE_CYCLES - 1)) begin
					next_state = ipc_pkg::IPC_IDLE;
					next_timer = 32'h0;
					if (cycle_write) begin
						next_stored = first_copy;
					end else begin
						next_granted = (first_copy == stored);
					end
				end else begin
					next_timer = timer + 32'h1;
				end
			end
			ipc_pkg::IPC_IDLE: begin
				if (start_ev) begin
					next_state    = ipc_pkg::IPC_RECV;
					next_bit_cnt  = 4'h0;
					next_byte_cnt = ipc_pkg::BYTE_SELECT;
					next_frame_ok = 1'b1;
				end
			end
			ipc_pkg::IPC_RECV: begin
				if (scl_rise) begin
					next_shift   = b;
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == ipc_pkg::BITS_DATA - 4'h1) begin
						next_state = ipc_pkg::IPC_ACK;
						case (byte_cnt)
							ipc_pkg::BYTE_SELECT: begin
								next_frame_ok = select_ok(b, cs_sync_h[1], cs_sync_l[1]);
							end
							ipc_pkg::BYTE_ADDR_HIGH: begin
								next_frame_ok = frame_ok && (b == ipc_pkg::ADDR_HIGH);
							end
							ipc_pkg::BYTE_ADDR_LOW: begin
								next_frame_ok = frame_ok && (b == ipc_pkg::ADDR_LOW);
							end
							ipc_pkg::BYTE_CODE: begin
								next_is_write = (b == ipc_pkg::CODE_WRITE);
								next_frame_ok = frame_ok && ((b == ipc_pkg::CODE_WRITE)
									|| (b == ipc_pkg::CODE_PRESENT));
							end
							default: begin
								if (byte_cnt < ipc_pkg::BYTE_CODE) begin
									next_first_copy = {first_copy[23:0], b};
								end else begin
									next_second_copy = {second_copy[23:0], b};
								end
							end
						endcase
					end
				end else if (start_ev) begin
					next_state    = ipc_pkg::IPC_RECV;
					next_bit_cnt  = 4'h0;
					next_byte_cnt = ipc_pkg::BYTE_SELECT;
					next_frame_ok = 1'b1;
				end else if (stop_ev) begin
					next_state = ipc_pkg::IPC_IDLE;
				end
			end
			ipc_pkg::IPC_ACK: begin
				// Unselected devices stand by without driving the ninth slot.
				if (scl_fall) begin
					if (frame_ok) begin
						next_ack_drive = 1'b1;
						next_state     = ipc_pkg::IPC_WAIT;
					end else begin
						next_state = ipc_pkg::IPC_IDLE;
					end
				end
			end
			ipc_pkg::IPC_WAIT: begin
				if (scl_fall) begin
					next_ack_drive = 1'b0;
					next_bit_cnt   = 4'h0;
					next_byte_cnt  = byte_cnt + 4'h1;
					next_state     = (byte_cnt == ipc_pkg::BYTE_LAST) ? ipc_pkg::IPC_TENTH
						: ipc_pkg::IPC_RECV;
				end
			end
			ipc_pkg::IPC_TENTH: begin
				if (stop_ev) begin
					next_timer = 32'h0;
					// Copies that differ trigger nothing, so rights and password stay.
					if (first_copy != second_copy) begin
						next_state = ipc_pkg::IPC_IDLE;
					end else if (is_write && !granted) begin
						next_state = ipc_pkg::IPC_IDLE;
					end else begin
						next_state       = ipc_pkg::IPC_BUSY;
						next_cycle_write = is_write;
						if (!is_write) begin
							next_granted = 1'b0;
						end
					end
				end else if (start_ev) begin
					next_state    = ipc_pkg::IPC_RECV;
					next_bit_cnt  = 4'h0;
					next_byte_cnt = ipc_pkg::BYTE_SELECT;
					next_frame_ok = 1'b1;
				end else if (scl_fall) begin
					// A stop needs the clock high first, so only a completed pulse cancels.
					next_state = ipc_pkg::IPC_IDLE;
				end
			end
			default: next_state = ipc_pkg::IPC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state       <= ipc_pkg::IPC_IDLE;
			bit_cnt     <= 4'h0;
			byte_cnt    <= 4'h0;
			shift       <= 8'h00;
			first_copy  <= 32'h0;
			second_copy <= 32'h0;
			is_write    <= 1'b0;
			frame_ok    <= 1'b0;
			cycle_write <= 1'b0;
			timer       <= 32'h0;
			granted     <= 1'b0;
			stored      <= ipc_pkg::PASSWORD_RESET;
			ack_drive   <= 1'b0;
		end else begin
			state       <= next_state;
			bit_cnt     <= next_bit_cnt;
			byte_cnt    <= next_byte_cnt;
			shift       <= next_shift;
			first_copy  <= next_first_copy;
			second_copy <= next_second_copy;
			is_write    <= next_is_write;
			frame_ok    <= next_frame_ok;
			cycle_write <= next_cycle_write;
			timer       <= next_timer;
			granted     <= next_granted;
			stored      <= next_stored;
			ack_drive   <= next_ack_drive;
		end
	end

	// Outputs are registered copies; the data pin is only ever pulled low.
	always_ff @(posedge clk) begin
		if (reset) begin
			sda_out          <= 1'b0;
			sda_oe           <= 1'b0;
			password_granted <= 1'b0;
			sector_writable  <= '0;
			busy             <= 1'b0;
			active_password  <= ipc_pkg::PASSWORD_RESET;
		end else begin
			sda_out          <= 1'b0;
			sda_oe           <= next_ack_drive;
			password_granted <= next_granted;
			sector_writable  <= ~sector_lock | {ipc_pkg::SECTORS{next_granted}};
			busy             <= (next_state == ipc_pkg::IPC_BUSY);
			active_password  <= next_stored;
		end
	end

	property p_busy_quiet;
		@(posedge clk) disable iff (reset) (state == ipc_pkg::IPC_BUSY) |=> !sda_oe;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("Data driven in cycle.");

	property p_busy_no_start;
		@(posedge clk) disable iff (reset)
			(state == ipc_pkg::IPC_BUSY && timer != 32'(WRITE_CYCLES - 1))
			|=> state == ipc_pkg::IPC_BUSY;
	endproperty
	a_busy_no_start: assert property (p_busy_no_start) else $error("Left cycle early.");

	property p_mismatch;
		@(posedge clk) disable iff (reset)
			(state == ipc_pkg::IPC_TENTH && stop_ev && first_copy != second_copy)
			|=> state == ipc_pkg::IPC_IDLE && $stable(granted) && $stable(stored);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("Mismatched copies acted.");

	property p_write_needs_grant;
		@(posedge clk) disable iff (reset) $changed(stored) |-> $past(granted);
	endproperty
	a_write_needs_grant: assert property (p_write_needs_grant) else $error("Ungranted write.");

	property p_start_cycle;
		@(posedge clk) disable iff (reset)
			(state == ipc_pkg::IPC_TENTH && stop_ev && first_copy == second_copy && !is_write)
			|=> state == ipc_pkg::IPC_BUSY;
	endproperty
	a_start_cycle: assert property (p_start_cycle) else $error("Delay not started.");

	property p_grant_only_end;
		@(posedge clk) disable iff (reset)
			$rose(granted) |-> $past(state) == ipc_pkg::IPC_BUSY && !$past(cycle_write);
	endproperty
	a_grant_only_end: assert property (p_grant_only_end) else $error("Grant at wrong time.");

	property p_active;
		@(posedge clk) disable iff (reset)
			(state == ipc_pkg::IPC_BUSY && cycle_write && timer == 32'(WRITE_CYCLES - 1))
			|=> active_password == $past(first_copy);
	endproperty
	a_active: assert property (p_active) else $error("Active password stale.");

	property p_ack_slot;
		@(posedge clk) disable iff (reset) $rose(sda_oe) |-> $past(state) == ipc_pkg::IPC_ACK;
	endproperty
	a_ack_slot: assert property (p_ack_slot) else $error("Ack outside ninth slot.");

	property p_tenth_cancel;
		@(posedge clk) disable iff (reset) (state == ipc_pkg::IPC_TENTH && scl_fall)
			|=> state == ipc_pkg::IPC_IDLE;
	endproperty
	a_tenth_cancel: assert property (p_tenth_cancel) else $error("Late stop acted.");

	property p_deselect_quiet;
		@(posedge clk) disable iff (reset) (state == ipc_pkg::IPC_ACK && scl_fall && !frame_ok)
			|=> state == ipc_pkg::IPC_IDLE && !sda_oe;
	endproperty
	a_deselect_quiet: assert property (p_deselect_quiet) else $error("Unselected ack.");
endmodule : ipc_i2c_password_slave

// *** bench/ipc_bus_master.sv ***
module ipc_bus_master (
	// Clock.
	input  wire logic clk,
	// Bus pins; the data line is released by driving one and pulled up.
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_wire
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// The line moves only while the clock is low, so a sample can never see an edge.
	task automatic put_bit(input logic b, output logic s);
		sda_drv <= b;
		tick(5);
		scl <= 1'b1;
		tick(5);
		#1 s = sda_wire;
		tick(5);
		scl <= 1'b0;
		tick(5);
	endtask : put_bit

	// Tail 1 puts one stray bit before the stop so it misses the tenth slot.
	task automatic frame(input logic [95:0] msg, input int n, input int tail, output int acks);
		logic s;
		acks = 0;
		sda_drv <= 1'b1;
		tick(5);
		scl <= 1'b1;
		tick(5);
		sda_drv <= 1'b0;
		tick(5);
		scl <= 1'b0;
		tick(5);
		for (int i = 0; i < n; i++) begin
			for (int j = 95; j > 87; j--) put_bit(msg[j - 8 * i], s);
			put_bit(1'b1, s);
			if (s === 1'b0) acks++;
		end
		if (tail == 1) put_bit(1'b0, s);
		sda_drv <= 1'b0;
		tick(5);
		scl <= 1'b1;
		tick(5);
		sda_drv <= 1'b1;
		tick(5);
	endtask : frame
endmodule : ipc_bus_master

// *** bench/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        reset;
	logic        scl;
	logic        sda_drv;
	logic        sda_in;
	logic        sda_out;
	logic        sda_oe;
	logic        csh;
	logic        csl;
	logic [63:0] lock;
	logic        password_granted;
	logic [63:0] sector_writable;
	logic        busy;
	logic [31:0] active_password;
	logic        granted_m;
	logic [31:0] stored_m;
	logic [7:0]  sel_ok;
	logic [31:0] r;
	int          num_errors;
	int          checks_done;
	int          cycles;

	assign sda_in = sda_oe ? sda_out : sda_drv;

	ipc_i2c_password_slave #(.WRITE_CYCLES(400)) dut (
		.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .chip_select_high_pin(csh), .chip_select_low_pin(csl),
		.sector_lock(lock), .password_granted(password_granted),
		.sector_writable(sector_writable), .busy(busy), .active_password(active_password)
	);

	ipc_bus_master m (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_in));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	function automatic logic [63:0] exp_wr(input logic [63:0] l, input logic g);
		return g ? '1 : ~l;
	endfunction : exp_wr

	task automatic settle();
		chk("granted", password_granted, granted_m);
		chk("password", active_password, stored_m);
		chk("writable", sector_writable, exp_wr(lock, granted_m));
	endtask : settle

	// The bench keeps its own grant and password and moves them only when a cycle runs.
	task automatic cmd(input logic [7:0] sel, code, input logic [31:0] a, b, input int tail);
		int   acks;
		int   k;
		logic ok;
		logic go;
		ok = (sel == sel_ok) && (code == ipc_pkg::CODE_PRESENT || code == ipc_pkg::CODE_WRITE);
		go = ok && tail == 0 && a == b && (code == ipc_pkg::CODE_PRESENT || granted_m);
		m.frame({sel, ipc_pkg::ADDR_HIGH, ipc_pkg::ADDR_LOW, a, code, b}, 12, tail, acks);
		chk("acks", acks, ok ? 12 : (sel == sel_ok ? 7 : 0));
		m.tick(2);
		chk("busy", busy, go);
		if (go) begin
			m.frame({sel_ok, 88'h0}, 1, 0, acks);
			chk("busy ack", acks, 0);
			k = 0;
			while (busy === 1'b1 && k < 1000) begin
				m.tick(1);
				k++;
			end
			chk("busy end", busy, 1'b0);
			if (code == ipc_pkg::CODE_PRESENT) granted_m = (a == stored_m);
			else stored_m = a;
		end
		m.tick(4);
		settle();
		$display("command %h tail %0d done", code, tail);
	endtask : cmd

	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			summarize();
		end
	end

	initial begin
		reset = 1'b1;
		csh = 1'b0;
		csl = 1'b0;
		lock = '0;
		num_errors = 0;
		checks_done = 0;
		cycles = 0;
		void'($urandom(32'hec6e));
		granted_m = 1'b0;
		stored_m = ipc_pkg::PASSWORD_RESET;
		@(posedge clk);
		csh <= 1'($urandom);
		csl <= 1'($urandom);
		lock <= {$urandom, $urandom};
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		sel_ok = {ipc_pkg::TYPE_NIBBLE, 1'b1, csh, csl, 1'b0};
		r = $urandom | 32'h0000_0001;
		settle();
		cmd(sel_ok, ipc_pkg::CODE_WRITE, r, r, 0);
		cmd(sel_ok, ipc_pkg::CODE_PRESENT, r, r, 0);
		cmd(sel_ok, ipc_pkg::CODE_PRESENT, 32'h0, 32'h0, 0);
		cmd(sel_ok, ipc_pkg::CODE_PRESENT, 32'h0, 32'h1, 0);
		cmd(sel_ok, ipc_pkg::CODE_PRESENT, 32'h0, 32'h0, 1);
		cmd(sel_ok ^ 8'h02, ipc_pkg::CODE_PRESENT, 32'h0, 32'h0, 0);
		cmd(sel_ok ^ 8'h80, ipc_pkg::CODE_PRESENT, 32'h0, 32'h0, 0);
		cmd(sel_ok, 8'h08, 32'h0, 32'h0, 0);
		cmd(sel_ok, ipc_pkg::CODE_WRITE, r, ~r, 0);
		cmd(sel_ok, ipc_pkg::CODE_WRITE, r, r, 1);
		cmd(sel_ok, ipc_pkg::CODE_WRITE, r, r, 0);
		cmd(sel_ok, ipc_pkg::CODE_PRESENT, 32'h0, 32'h0, 0);
		cmd(sel_ok, ipc_pkg::CODE_PRESENT, r, r, 0);
		summarize();
	end
endmodule : tb_top
